// >>> hdl/stk_pkg.sv
package stk_pkg;

   // ****************************************************************
   // host i/o decode
   // ****************************************************************
   localparam logic [15:0] STK_DATA_PORT_BASE = 16'hFA80;
   localparam logic [15:0] STK_DATA_PORT_MASK = 16'hFF80;
   localparam int          STK_SERIAL_BIT     = 0;
   localparam int          STK_ENABLE_BIT     = 4;

   // ****************************************************************
   // command byte fields
   // ****************************************************************
   localparam int          STK_CMD_VALID_BIT  = 7;
   localparam int          STK_CMD_RAM_BIT    = 6;
   localparam int          STK_CMD_ADDR_LSB   = 1;
   localparam int          STK_CMD_ADDR_MSB   = 5;
   localparam int          STK_CMD_READ_BIT   = 0;
   localparam logic [4:0]  STK_BURST_ADDR     = 5'h1F;
   localparam logic [2:0]  STK_LAST_BIT       = 3'h7;

   // ****************************************************************
   // storage sizes
   // ****************************************************************
   localparam int          STK_RAM_BYTES      = 24;
   localparam int          STK_CLK_BYTES      = 8;

   // ****************************************************************
   // clock register indexes and command addresses
   // ****************************************************************
   localparam logic [7:0]  STK_CMD_SECONDS    = 8'h80;
   localparam logic [7:0]  STK_CMD_MINUTES    = 8'h82;
   localparam logic [7:0]  STK_CMD_HOURS      = 8'h84;
   localparam logic [7:0]  STK_CMD_DATE       = 8'h86;
   localparam logic [7:0]  STK_CMD_MONTH      = 8'h88;
   localparam logic [7:0]  STK_CMD_WEEKDAY    = 8'h8A;
   localparam logic [7:0]  STK_CMD_YEAR       = 8'h8C;
   localparam logic [7:0]  STK_CMD_WPROT      = 8'h8E;
   localparam logic [2:0]  STK_IDX_SEC        = 3'h0;
   localparam logic [2:0]  STK_IDX_MIN        = 3'h1;
   localparam logic [2:0]  STK_IDX_HOUR       = 3'h2;
   localparam logic [2:0]  STK_IDX_DATE       = 3'h3;
   localparam logic [2:0]  STK_IDX_MONTH      = 3'h4;
   localparam logic [2:0]  STK_IDX_WDAY       = 3'h5;
   localparam logic [2:0]  STK_IDX_YEAR       = 3'h6;
   localparam logic [2:0]  STK_IDX_WPROT      = 3'h7;

   // ****************************************************************
   // register fields
   // ****************************************************************
   localparam int          STK_HALT_BIT       = 7;
   localparam int          STK_MODE12_BIT     = 7;
   localparam int          STK_MERIDIEM_BIT   = 5;
   localparam int          STK_WLOCK_BIT      = 7;
   localparam logic [7:0]  STK_WPROT_MASK     = 8'h80;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0]  STK_RST_SECONDS    = 8'h00;
   localparam logic [7:0]  STK_RST_MINUTES    = 8'h00;
   localparam logic [7:0]  STK_RST_HOURS      = 8'h00;
   localparam logic [7:0]  STK_RST_DATE       = 8'h01;
   localparam logic [7:0]  STK_RST_MONTH      = 8'h01;
   localparam logic [7:0]  STK_RST_WEEKDAY    = 8'h01;
   localparam logic [7:0]  STK_RST_YEAR       = 8'h00;
   localparam logic [7:0]  STK_RST_WPROT      = 8'h00;
   localparam logic [7:0]  STK_RST_RAM        = 8'h00;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int          STK_CLK_MHZ        = 100;
   localparam int          STK_TICK_MS        = 1000;
   localparam int          STK_TICK_CYCLES    = STK_TICK_MS * 1000 * STK_CLK_MHZ;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      STK_ST_CMD  = 2'b00,
      STK_ST_DATA = 2'b01,
      STK_ST_DONE = 2'b11
   } stk_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } stk_io_req_t;

endpackage : stk_pkg

// >>> hdl/stk_timekeeper.sv
`timescale 1ns/100ps
`default_nettype none

module stk_timekeeper
   import stk_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = STK_TICK_CYCLES
)(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire stk_io_req_t io_req_i,
   input  wire logic        link_enable_i,
   output logic [7:0]       io_rdata_o
);

   // ****************************************************************
   // bcd helpers
   // ****************************************************************
   function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                            input logic [7:0] max,
                                            input logic [7:0] min);
      logic [7:0] n;
      n = v;
      if (v >= max)
         return {1'b1, min};
      if (v[3:0] >= 4'h9)
         n = {v[7:4] + 4'h1, 4'h0};
      else
         n = {v[7:4], v[3:0] + 4'h1};
      return {1'b0, n};
   endfunction : bcd_step

   function automatic logic [7:0] month_end(input logic [7:0] mon,
                                            input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
         8'h02:   return leap ? 8'h29 : 8'h28;
         8'h04,
         8'h06,
         8'h09,
         8'h11:   return 8'h30;
         default: return 8'h31;
      endcase
   endfunction : month_end

   // ****************************************************************
   // storage and state
   // ****************************************************************
   logic [7:0]  tk_q [STK_CLK_BYTES];
   logic [7:0]  ram_q [STK_RAM_BYTES];
   stk_state_t  state_q;
   logic [7:0]  cmd_q;
   logic [2:0]  bit_q;
   logic [4:0]  idx_q;
   logic [4:0]  nbytes_q;
   logic [7:0]  sh_q;
   logic [7:0]  snap_q;
   logic [31:0] tick_q;
   logic [7:0]  rdata_q;

   logic        acc;
   logic        in_bit;
   logic [7:0]  cmd_d;
   logic        is_ram;
   logic        is_read;
   logic        burst;
   logic        idx_ok;
   logic [7:0]  cur_byte;
   logic        out_bit;
   logic [7:0]  wr_byte;
   logic        commit;
   logic        tick;

   // ****************************************************************
   // access decode
   // ****************************************************************
   always_comb
   begin
      acc    = link_enable_i && (io_req_i.rd || io_req_i.wr) &&
               ((io_req_i.addr & STK_DATA_PORT_MASK) == STK_DATA_PORT_BASE);
      in_bit = io_req_i.wr & io_req_i.wdata[STK_SERIAL_BIT];
      cmd_d  = {in_bit, cmd_q[7:1]};
   end

   assign is_ram  = cmd_q[STK_CMD_RAM_BIT];
   assign is_read = cmd_q[STK_CMD_READ_BIT];
   assign burst   = cmd_q[STK_CMD_ADDR_MSB:STK_CMD_ADDR_LSB] == STK_BURST_ADDR;

   // ****************************************************************
   // selected byte
   // ****************************************************************
   always_comb
   begin
      if (is_ram)
         idx_ok = idx_q < 5'(STK_RAM_BYTES);
      else
         idx_ok = idx_q < 5'(STK_CLK_BYTES);
      cur_byte = 8'h00;
      if (idx_ok && is_ram)
         cur_byte = ram_q[idx_q];
      else if (idx_ok)
         cur_byte = tk_q[idx_q[2:0]];
      if (!is_ram && idx_q[2:0] == STK_IDX_WPROT)
         cur_byte = cur_byte & STK_WPROT_MASK;
      out_bit = (bit_q == 3'h0) ? cur_byte[0] : snap_q[bit_q];
      wr_byte = {in_bit, sh_q[7:1]};
      commit  = acc && state_q == STK_ST_DATA && !is_read && bit_q == STK_LAST_BIT &&
                idx_ok && (!tk_q[STK_IDX_WPROT][STK_WLOCK_BIT] ||
                           (!is_ram && idx_q[2:0] == STK_IDX_WPROT));
   end

   // ****************************************************************
   // serial sequencer
   // ****************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q  <= STK_ST_CMD;
         cmd_q    <= 8'h00;
         bit_q    <= 3'h0;
         idx_q    <= 5'h00;
         nbytes_q <= 5'h00;
         sh_q     <= 8'h00;
         snap_q   <= 8'h00;
      end
      else if (!link_enable_i)
      begin
         state_q <= STK_ST_CMD;
         bit_q   <= 3'h0;
      end
      else if (acc)
      begin
         case (state_q)
            STK_ST_CMD:
            begin
               cmd_q <= cmd_d;
               bit_q <= bit_q + 3'h1;
               if (bit_q == STK_LAST_BIT)
               begin
                  state_q  <= cmd_d[STK_CMD_VALID_BIT] ? STK_ST_DATA : STK_ST_DONE;
                  nbytes_q <= 5'h00;
                  if (cmd_d[STK_CMD_ADDR_MSB:STK_CMD_ADDR_LSB] == STK_BURST_ADDR)
                     idx_q <= 5'h00;
                  else
                     idx_q <= cmd_d[STK_CMD_ADDR_MSB:STK_CMD_ADDR_LSB];
               end
            end
            STK_ST_DATA:
            begin
               bit_q <= bit_q + 3'h1;
               sh_q  <= wr_byte;
               if (bit_q == 3'h0)
                  snap_q <= cur_byte;
               if (bit_q == STK_LAST_BIT)
               begin
                  idx_q    <= idx_q + 5'h01;
                  nbytes_q <= nbytes_q + 5'h01;
                  if (!burst ||
                      nbytes_q == (is_ram ? 5'(STK_RAM_BYTES - 1) : 5'(STK_CLK_BYTES - 1)))
                     state_q <= STK_ST_DONE;
               end
            end
            STK_ST_DONE:
               state_q <= STK_ST_DONE;
            default:
               state_q <= STK_ST_DONE;
         endcase
      end
   end

   // ****************************************************************
   // read data return
   // ****************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_q <= 8'h00;
      else if (acc && io_req_i.rd && state_q != STK_ST_DONE)
         rdata_q <= {7'h00, state_q == STK_ST_DATA && is_read && out_bit};
   end

   assign io_rdata_o = rdata_q;

   // ****************************************************************
   // general purpose ram
   // ****************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < STK_RAM_BYTES; i++)
            ram_q[i] <= STK_RST_RAM;
      end
      else if (commit && is_ram)
         ram_q[idx_q] <= wr_byte;
   end

   // ****************************************************************
   // one second tick
   // ****************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tick_q <= 32'h0000_0000;
      else if (tk_q[STK_IDX_SEC][STK_HALT_BIT])
         tick_q <= 32'h0000_0000;
      else if (tick_q >= TICK_CYCLES - 1)
         tick_q <= 32'h0000_0000;
      else
         tick_q <= tick_q + 32'h0000_0001;
   end

   assign tick = !tk_q[STK_IDX_SEC][STK_HALT_BIT] && tick_q >= TICK_CYCLES - 1;

   // ****************************************************************
   // clock and calendar
   // ****************************************************************
   logic [7:0] nx [STK_CLK_BYTES];

   always_comb
   begin
      logic [8:0] r;
      logic       cy;
      logic [4:0] h;
      r  = 9'h000;
      cy = 1'b0;
      h  = 5'h00;
      for (int i = 0; i < STK_CLK_BYTES; i++)
         nx[i] = tk_q[i];
      r = bcd_step({1'b0, tk_q[STK_IDX_SEC][6:0]}, 8'h59, 8'h00);
      nx[STK_IDX_SEC] = {tk_q[STK_IDX_SEC][STK_HALT_BIT], r[6:0]};
      cy = r[8];
      if (cy)
      begin
         r  = bcd_step(tk_q[STK_IDX_MIN], 8'h59, 8'h00);
         nx[STK_IDX_MIN] = r[7:0];
         cy = r[8];
      end
      if (cy && tk_q[STK_IDX_HOUR][STK_MODE12_BIT])
      begin
         h  = tk_q[STK_IDX_HOUR][4:0];
         cy = 1'b0;
         if (h == 5'h11)
         begin
            nx[STK_IDX_HOUR] = tk_q[STK_IDX_HOUR] ^ 8'h23;
            cy = tk_q[STK_IDX_HOUR][STK_MERIDIEM_BIT];
         end
         else if (h == 5'h12)
            nx[STK_IDX_HOUR] = {tk_q[STK_IDX_HOUR][7:5], 5'h01};
         else
         begin
            r = bcd_step({3'h0, h}, 8'h12, 8'h01);
            nx[STK_IDX_HOUR] = {tk_q[STK_IDX_HOUR][7:5], r[4:0]};
         end
      end
      else if (cy)
      begin
         r  = bcd_step({2'h0, tk_q[STK_IDX_HOUR][5:0]}, 8'h23, 8'h00);
         nx[STK_IDX_HOUR] = {tk_q[STK_IDX_HOUR][7:6], r[5:0]};
         cy = r[8];
      end
      if (cy)
      begin
         r = bcd_step(tk_q[STK_IDX_WDAY], 8'h07, 8'h01);
         nx[STK_IDX_WDAY] = r[7:0];
         r  = bcd_step(tk_q[STK_IDX_DATE],
                       month_end(tk_q[STK_IDX_MONTH], tk_q[STK_IDX_YEAR]), 8'h01);
         nx[STK_IDX_DATE] = r[7:0];
         cy = r[8];
      end
      if (cy)
      begin
         r  = bcd_step(tk_q[STK_IDX_MONTH], 8'h12, 8'h01);
         nx[STK_IDX_MONTH] = r[7:0];
         cy = r[8];
      end
      if (cy)
      begin
         r = bcd_step(tk_q[STK_IDX_YEAR], 8'h99, 8'h00);
         nx[STK_IDX_YEAR] = r[7:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tk_q[STK_IDX_SEC]   <= STK_RST_SECONDS;
         tk_q[STK_IDX_MIN]   <= STK_RST_MINUTES;
         tk_q[STK_IDX_HOUR]  <= STK_RST_HOURS;
         tk_q[STK_IDX_DATE]  <= STK_RST_DATE;
         tk_q[STK_IDX_MONTH] <= STK_RST_MONTH;
         tk_q[STK_IDX_WDAY]  <= STK_RST_WEEKDAY;
         tk_q[STK_IDX_YEAR]  <= STK_RST_YEAR;
         tk_q[STK_IDX_WPROT] <= STK_RST_WPROT;
      end
      else if (commit && !is_ram)
      begin
         // host write wins over a tick in the same cycle
         if (idx_q[2:0] == STK_IDX_WPROT)
            tk_q[STK_IDX_WPROT] <= wr_byte & STK_WPROT_MASK;
         else
            tk_q[idx_q[2:0]] <= wr_byte;
      end
      else if (tick)
      begin
         for (int i = 0; i < STK_CLK_BYTES; i++)
            tk_q[i] <= nx[i];
      end
   end

endmodule : stk_timekeeper

`default_nettype wire

// >>> verification/stk_host.sv
`timescale 1ns/100ps
`default_nettype none

// ********
// host side: bit-banged data port and control bit
// ********
module stk_host
   import stk_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic [7:0]  io_rdata_i,
   output var  stk_io_req_t io_req_o,
   output var  logic        link_enable_o
);
   logic [6:0] alias_q = 7'h00;
   initial io_req_o = '0;
   initial link_enable_o = 1'b0;

   // one strobe pulse, then one idle cycle before sampling
   task automatic acc(input logic rd, input logic b, input logic [15:0] a, output logic r);
      @(negedge clk_sys_i);
      io_req_o = '{addr: a, rd: rd, wr: !rd, wdata: {7'h00, b}};
      @(negedge clk_sys_i);
      io_req_o = '{addr: a, rd: 1'b0, wr: 1'b0, wdata: ~io_req_o.wdata};
      @(negedge clk_sys_i);
      r = io_rdata_i[0];
   endtask : acc

   task automatic xfer(input logic [7:0] w, input logic rd, output logic [7:0] r);
      for (int i = 0; i < 8; i++)
      begin
         acc(rd, w[i], STK_DATA_PORT_BASE | {9'h000, alias_q}, r[i]);
         alias_q = alias_q + 7'h01;
      end
   endtask : xfer

   task automatic link(input logic on);
      @(negedge clk_sys_i);
      link_enable_o = on;
   endtask : link

   task automatic cmd(input logic [7:0] c);
      logic [7:0] junk;
      link(1'b0);
      link(1'b1);
      xfer(c, 1'b0, junk);
   endtask : cmd

   // reads that must not be taken; expansion range never touched
   task automatic stray(output logic r);
      acc(1'b1, 1'b0, 16'hFA7F, r);
      link(1'b0);
      acc(1'b1, 1'b0, STK_DATA_PORT_BASE, r);
   endtask : stray
endmodule : stk_host

`default_nettype wire

// >>> verification/stk_timekeeper_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module stk_timekeeper_asserts
   import stk_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = STK_TICK_CYCLES
)(
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire stk_io_req_t io_req_i,
   input wire logic        link_enable_i,
   input wire logic [7:0]  io_rdata_o
);
   // ********
   // transfer tracking
   // ********
   logic       in_rng;
   logic       tk_rd;
   logic       burst;
   logic       rd_ph;
   logic [8:0] lim;
   logic [8:0] idx;
   logic [8:0] cnt_q;
   logic [7:0] cmd_q;
   logic [7:0] sh_q;
   logic       pend_q;
   logic [2:0] pidx_q;
   logic       done_q;

   assign in_rng = (io_req_i.addr & STK_DATA_PORT_MASK) == STK_DATA_PORT_BASE;
   assign tk_rd  = link_enable_i && io_req_i.rd && in_rng;
   assign burst  = cmd_q[5:1] == STK_BURST_ADDR;
   assign lim    = !cmd_q[7] ? 9'h008 : (!burst ? 9'h010 : (cmd_q[6] ? 9'h0C8 : 9'h048));
   assign idx    = cnt_q - 9'h008;
   assign rd_ph  = cmd_q[7] && cmd_q[0] && cnt_q >= 9'h008 && cnt_q < lim;

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt_q <= 9'h000;
      else if (!link_enable_i)
         cnt_q <= 9'h000;
      else if (in_rng && (io_req_i.rd || io_req_i.wr) && cnt_q != 9'h1FF)
         cnt_q <= cnt_q + 9'h001;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cmd_q <= 8'h00;
      else if (link_enable_i && in_rng && io_req_i.wr && cnt_q < 9'h008)
         cmd_q <= {io_req_i.wdata[0], cmd_q[7:1]};
   end

   // assembles each single-byte read as the host sees it
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pend_q <= 1'b0;
         pidx_q <= 3'h0;
         sh_q   <= 8'h00;
         done_q <= 1'b0;
      end
      else
      begin
         pend_q <= tk_rd && rd_ph;
         pidx_q <= idx[2:0];
         done_q <= pend_q && pidx_q == STK_LAST_BIT;
         if (pend_q)
            sh_q <= {io_rdata_o[0], sh_q[7:1]};
      end
   end

   // ********
   // checks
   // ********
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   upper_zero_a: assert property (io_rdata_o[7:1] == 7'h00)
      else $error("read data upper bits not zero");
   alias_range_a: assert property (io_req_i.rd && !in_rng |=> $stable(io_rdata_o))
      else $error("read outside data port moved read data");
   link_off_a: assert property (io_req_i.rd && !link_enable_i |=> $stable(io_rdata_o))
      else $error("read with line disabled moved read data");
   past_end_a: assert property (tk_rd && cnt_q >= 9'h008 && cnt_q >= lim
      |=> $stable(io_rdata_o)) else $error("read past transfer end moved read data");
   bad_cmd_a: assert property (tk_rd && cnt_q >= 9'h008 && !cmd_q[7]
      |=> io_rdata_o == $past(io_rdata_o)) else $error("ignored command answered");
   ram_hole_a: assert property (tk_rd && rd_ph && cmd_q[6] && !burst
      && cmd_q[5:1] >= 5'h18 |=> io_rdata_o == 8'h00) else $error("missing ram byte not zero");
   wprot_zero_a: assert property (tk_rd && rd_ph && (cmd_q == 8'h8F && idx < 9'h007
      || cmd_q == 8'hBF && idx >= 9'h038 && idx < 9'h03F) |=> io_rdata_o == 8'h00)
      else $error("write lock low bits not zero");
   bcd_time_a: assert property (done_q && (cmd_q == 8'h81 || cmd_q == 8'h83)
      |-> sh_q[3:0] <= 4'h9 && sh_q[6:4] <= 3'h5) else $error("time byte not bcd");
endmodule : stk_timekeeper_asserts

`default_nettype wire

// >>> verification/stk_timekeeper_test.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("[FAIL] t=%0t got %h expected %h", $time, (got), (exp)); \
      end \
   end

module stk_timekeeper_test
   import stk_pkg::*;
;
   localparam int unsigned TICK = 400;
   localparam logic [7:0]  RST [8] = '{STK_RST_SECONDS, STK_RST_MINUTES, STK_RST_HOURS,
      STK_RST_DATE, STK_RST_MONTH, STK_RST_WEEKDAY, STK_RST_YEAR, STK_RST_WPROT};
   // hour, date, month, year in; hour, date, month out
   localparam logic [55:0] ROLL [4] = '{56'h23_28_02_01_00_01_03, 56'h23_28_02_04_00_29_02,
      56'h23_30_04_01_00_01_05, 56'h91_15_06_01_B2_15_06};
   logic        clk_sys_i;
   logic        rst_n_i;
   stk_io_req_t io_req;
   logic        link_en;
   logic [7:0]  rdata;
   logic [7:0]  wq [24];
   logic [7:0]  rq [24];
   logic [7:0]  v;
   logic [63:0] p;
   logic        b;
   int          fails = 0;
   int          cmp_count = 0;

   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   stk_host u_stk_host (.clk_sys_i(clk_sys_i), .io_rdata_i(rdata), .io_req_o(io_req),
      .link_enable_o(link_en));
   stk_timekeeper #(.TICK_CYCLES(TICK)) u_stk_timekeeper (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .io_req_i(io_req), .link_enable_i(link_en), .io_rdata_o(rdata));

   // ********
   // register access
   // ********
   task automatic wreg(input logic [7:0] c, input logic [7:0] d);
      u_stk_host.cmd(c);
      u_stk_host.xfer(d, 1'b0, v);
   endtask : wreg

   task automatic rreg(input logic [7:0] c, output logic [7:0] d);
      u_stk_host.cmd(c);
      u_stk_host.xfer(8'h00, 1'b1, d);
   endtask : rreg

   task automatic burst(input logic [7:0] c, input int n);
      u_stk_host.cmd(c);
      for (int i = 0; i < n; i++)
         u_stk_host.xfer(wq[i], c[0], rq[i]);
   endtask : burst

   task automatic conclude();
      $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (60000) @(posedge clk_sys_i);
      fails++;
      $display("[FAIL] t=%0t run did not finish", $time);
      conclude();
   end

   // ********
   // tests
   // ********
   initial
   begin
      rst_n_i = 1'b0;
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      burst(8'hBF, 8);
      for (int i = 0; i < 8; i++)
         `CHK(rq[i], RST[i])
      $display("test reset values done");
      foreach (ROLL[k])
      begin
         p = {8'hD9, 8'h59, ROLL[k][55:32], 8'h01, ROLL[k][31:24], 8'h00};
         for (int i = 0; i < 8; i++)
            wq[i] = p[63 - 8 * i -: 8];
         burst(8'hBE, 8);
         wreg(STK_CMD_SECONDS, 8'h59);
         repeat (TICK + 40) @(negedge clk_sys_i);
         burst(8'hBF, 8);
         `CHK(rq[1], 8'h00)
         `CHK(rq[2], ROLL[k][23:16])
         `CHK(rq[3], ROLL[k][15:8])
         `CHK(rq[4], ROLL[k][7:0])
      end
      $display("test calendar rollover done");
      wreg(STK_CMD_SECONDS, 8'hD0);
      repeat (2 * TICK) @(negedge clk_sys_i);
      rreg(8'h81, v);
      `CHK(v, 8'hD0)
      rreg(8'h83, v);
      `CHK(v, 8'h00)
      $display("test clock halt done");
      for (int i = 0; i < 24; i++)
         wq[i] = 8'h03 + 8'(i) * 8'h13;
      burst(8'hFE, 24);
      burst(8'hFF, 24);
      for (int i = 0; i < 24; i++)
         `CHK(rq[i], wq[i])
      rreg(8'hEF, v);
      `CHK(v, wq[23])
      $display("test ram burst done");
      wreg(8'hCC, 8'h3C);
      u_stk_host.xfer(8'hFF, 1'b0, v);
      rreg(8'hCD, v);
      `CHK(v, 8'h3C)
      rreg(8'hCF, v);
      `CHK(v, wq[7])
      u_stk_host.acc(1'b1, 1'b0, STK_DATA_PORT_BASE, b);
      `CHK(b, wq[7][7])
      u_stk_host.stray(b);
      `CHK(b, wq[7][7])
      wreg(8'hF0, 8'hFF);
      rreg(8'hF1, v);
      `CHK(v, 8'h00)
      u_stk_host.cmd(8'h4C);
      u_stk_host.xfer(8'h00, 1'b0, v);
      u_stk_host.acc(1'b1, 1'b0, STK_DATA_PORT_BASE, b);
      rreg(8'hCD, v);
      `CHK(v, 8'h3C)
      $display("test refused accesses done");
      wreg(STK_CMD_WPROT, 8'hFF);
      rreg(8'h8F, v);
      `CHK(v, STK_WPROT_MASK)
      wreg(8'hCC, 8'h00);
      rreg(8'hCD, v);
      `CHK(v, 8'h3C)
      wreg(STK_CMD_WPROT, 8'h00);
      wreg(8'hCC, 8'hA5);
      rreg(8'hCD, v);
      `CHK(v, 8'hA5)
      $display("test write lock done");
      conclude();
   end
endmodule : stk_timekeeper_test

bind stk_timekeeper stk_timekeeper_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_stk_timekeeper_asserts (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .io_req_i(io_req_i),
   .link_enable_i(link_enable_i), .io_rdata_o(io_rdata_o));

`default_nettype wire
